// ==== hw/slx_crossbar.sv ====
// registered physical to logical lane crossbar
`timescale 1ns/1ps
module slx_crossbar #(
  parameter int NUM_LANES = 8,
  parameter int LANE_W    = 32
) (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             reset_n,
  // selects
  slx_xbar_if.xbar                              sel_if,
  // lanes
  input  wire logic [NUM_LANES-1:0][LANE_W-1:0] phys_lane_data,
  output logic      [NUM_LANES-1:0][LANE_W-1:0] logical_lane_data
);
  logic [NUM_LANES-1:0][LANE_W-1:0] next_logical;

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    assign next_logical[l] = phys_lane_data[sel_if.lane_src_sel[l]];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      logical_lane_data <= '0;
    end else begin
      logical_lane_data <= next_logical;
    end
  end
endmodule // slx_crossbar

// ==== hw/slx_lane_sync.sv ====
// lane crossbar, link delay setup and sysref sync logic with avalon-mm registers
// Function
// - lanes 0 and 1 sources from first register
// - lanes 2 to 7 in three more registers
// - field value x selects physical input x
// - 0xf1 enables sync, reset-on-trigger rotation
// - 0x02 in mode register selects one-shot
`timescale 1ns/1ps
module slx_lane_sync
  import slx_pkg::*;
#(
  parameter int NUM_LANES   = 8,
  parameter int LANE_W      = 32,
  parameter int LMFC_PERIOD = slx_pkg::LMFC_PERIOD_DEF,
  parameter int LMFC_W      = $clog2(LMFC_PERIOD)
) (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             reset_n,
  // avalon-mm slave
  input  wire logic [11:0]                      avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [31:0]                      avs_writedata,
  input  wire logic [3:0]                       avs_byteenable,
  output logic      [31:0]                      avs_readdata,
  output logic                                  avs_waitrequest,
  // serial lanes
  input  wire logic [NUM_LANES-1:0][LANE_W-1:0] serial_lane_input_pin,
  output logic      [NUM_LANES-1:0][LANE_W-1:0] logical_lane_data,
  // sync
  input  wire logic                             sysref,
  output logic                                  sync_align_pulse,
  output logic                                  sync_aligned,
  output logic      [LMFC_W-1:0]                lmfc_phase,
  // delay settings
  output logic      [7:0]                       link_delay_a_cfg,
  output logic      [7:0]                       link_delay_b_cfg,
  output logic      [7:0]                       latency_setup_a_cfg,
  output logic      [7:0]                       latency_setup_b_cfg
);
  import slx_pkg::*;

  // {hit, slot} for a register index
  function automatic logic [4:0] slot_of(input logic [9:0] idx);
    logic [4:0] r;
    r = 5'h00;
    case (idx)
      IDX_SYNC_MODE: r = {1'b1, SLOT_SYNC_MODE};
      IDX_SYNC_CTRL: r = {1'b1, SLOT_SYNC_CTRL};
      IDX_LDLY_A:    r = {1'b1, SLOT_LDLY_A};
      IDX_LDLY_B:    r = {1'b1, SLOT_LDLY_B};
      IDX_LAT_A:     r = {1'b1, SLOT_LAT_A};
      IDX_LAT_B:     r = {1'b1, SLOT_LAT_B};
      IDX_XBAR_01:   r = {1'b1, SLOT_XBAR_0};
      IDX_XBAR_23:   r = {1'b1, 4'(SLOT_XBAR_0 + 4'h1)};
      IDX_XBAR_45:   r = {1'b1, 4'(SLOT_XBAR_0 + 4'h2)};
      IDX_XBAR_67:   r = {1'b1, 4'(SLOT_XBAR_0 + 4'h3)};
      default:       r = 5'h00;
    endcase
    return r;
  endfunction

  // reset value of a storage slot; crossbar slots start as identity
  function automatic logic [7:0] reset_of(input int slot);
    logic [7:0] v;
    v = RST_ZERO;
    case (slot)
      int'(SLOT_XBAR_0):     v = RST_XBAR_01;
      int'(SLOT_XBAR_0) + 1: v = RST_XBAR_23;
      int'(SLOT_XBAR_0) + 2: v = RST_XBAR_45;
      int'(SLOT_XBAR_0) + 3: v = RST_XBAR_67;
      default: v = RST_ZERO;
    endcase
    return v;
  endfunction

  // three-bit source field of one lane out of a crossbar register
  function automatic logic [SEL_W-1:0] sel_field(input logic [7:0] r, input logic odd);
    logic [SEL_W-1:0] f;
    f = odd ? r[XBAR_ODD_LSB +: SEL_W] : r[XBAR_EVEN_LSB +: SEL_W];
    return f;
  endfunction

  // states in which the lanes count as aligned
  function automatic logic is_locked(input slx_sync_e st);
    logic hit;
    hit = (st == SYNC_ALIGNED) | (st == SYNC_TRACK);
    return hit;
  endfunction

  // register storage
  // one byte per slot; every slot reads back its stored value
  logic [7:0]  cfg_reg [0:NUM_SLOTS-1];

  // bus decode
  // register index is the word address; the two low address bits are ignored
  logic [9:0]  reg_index;
  logic [4:0]  slot_hit;
  logic        access_hit;
  logic [3:0]  access_slot;
  logic        stat_hit;
  logic        bus_req;
  logic        write_commit;
  logic        lane0_write;
  logic [7:0]  status_byte;
  logic [7:0]  read_byte;
  logic [31:0] next_readdata;

  assign reg_index    = avs_address[11:2];
  assign slot_hit     = slot_of(reg_index);
  assign access_hit   = slot_hit[4];
  assign access_slot  = slot_hit[3:0];
  assign stat_hit     = (reg_index == IDX_SYNC_STAT);
  assign bus_req      = avs_read | avs_write;
  assign write_commit = avs_write & ~avs_waitrequest;
  assign lane0_write  = write_commit & avs_byteenable[0] & access_hit;
  assign read_byte    = access_hit ? cfg_reg[access_slot] : (stat_hit ? status_byte : RST_ZERO);
  assign next_readdata = {24'h000000, read_byte};

  // one wait state per access; waitrequest low for exactly one cycle
  // waitrequest rises again at the commit edge, so a request that is
  // still held there is taken again only after one more wait state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // read data loaded at the edge that drops waitrequest, one before the commit edge, and held until the next read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // config registers; delay and latency values are held for the host's subclass 1 setup
  // writes without byte lane 0 and writes to unmapped indices are dropped;
  // the status index decodes for reads only
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        cfg_reg[s] <= reset_of(s);
      end else if (lane0_write && access_slot == 4'(s)) begin
        cfg_reg[s] <= avs_writedata[7:0];
      end
    end
  end

  // delay and latency bytes go out unchanged to the link delay logic
  assign link_delay_a_cfg    = cfg_reg[SLOT_LDLY_A];
  assign link_delay_b_cfg    = cfg_reg[SLOT_LDLY_B];
  assign latency_setup_a_cfg = cfg_reg[SLOT_LAT_A];
  assign latency_setup_b_cfg = cfg_reg[SLOT_LAT_B];

  // crossbar selects
  // selects leave the config side through the carrier interface
  slx_xbar_if #(.NUM_LANES(NUM_LANES)) xbar_sel ();

  // crossbar register k holds the sources of lanes 2k and 2k+1
  for (genvar k = 0; k < NUM_LANES / 2; k++) begin : g_pair
    assign xbar_sel.lane_src_sel[2*k]   = sel_field(cfg_reg[SLOT_XBAR_0 + k], 1'b0);
    assign xbar_sel.lane_src_sel[2*k+1] = sel_field(cfg_reg[SLOT_XBAR_0 + k], 1'b1);
  end

  // the crossbar adds one register stage; a new select is seen
  // on the edge after the one that stores it
  slx_crossbar #(
    .NUM_LANES (NUM_LANES),
    .LANE_W    (LANE_W)
  ) u_crossbar (
    .sys_clk           (sys_clk),
    .reset_n           (reset_n),
    .sel_if            (xbar_sel),
    .phys_lane_data    (serial_lane_input_pin),
    .logical_lane_data (logical_lane_data)
  );

  // sync control decode
  logic        sync_enable;
  logic        rot_reset;
  logic [1:0]  sync_mode;
  logic        arm_write;
  logic        ctrl_write;
  logic        mode_write;
  logic        mode_one_shot;
  logic        mode_continuous;

  assign sync_enable = cfg_reg[SLOT_SYNC_CTRL][CTRL_EN_BIT];
  assign rot_reset   = (cfg_reg[SLOT_SYNC_CTRL][CTRL_ROT_LSB +: 4] == ROT_RESET_ON_TRIG);
  assign sync_mode   = cfg_reg[SLOT_SYNC_MODE][MODE_LSB +: 2];
  // any committed mode or control write re-arms; enable is the stored value,
  // so arming from off needs enable set by an earlier write
  assign ctrl_write      = lane0_write & (access_slot == SLOT_SYNC_CTRL);
  assign mode_write      = lane0_write & (access_slot == SLOT_SYNC_MODE);
  assign mode_one_shot   = (sync_mode == MODE_ONE_SHOT);
  assign mode_continuous = (sync_mode == MODE_CONTINUOUS);
  assign arm_write       = mode_write | ctrl_write;

  // sysref edge, input synchronous to sys_clk
  // sysref idles low and the history flop resets low, so reset
  // release never shows a false edge
  logic        sysref_q;
  logic        sysref_edge;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
    end
  end

  assign sysref_edge = sysref & ~sysref_q;

  // sync state machine
  // off to armed on an arm write; armed to aligned (one-shot) or track
  // on the first edge; any arm write returns to armed
  slx_sync_e   sync_state;
  slx_sync_e   next_sync_state;
  logic        align_event;
  logic        ignored_edge;

  always_comb begin
    next_sync_state = sync_state;
    align_event     = 1'b0;
    ignored_edge    = 1'b0;
    case (sync_state)
      SYNC_OFF: begin
        if (sync_enable && arm_write) begin
          next_sync_state = SYNC_ARMED;
        end
      end
      SYNC_ARMED: begin
        // an armed machine takes any edge; in track only continuous mode takes one
        if (sysref_edge) begin
          align_event     = 1'b1;
          if (mode_one_shot) begin
            next_sync_state = SYNC_ALIGNED;
          end else begin
            next_sync_state = SYNC_TRACK;
          end
        end
      end
      SYNC_ALIGNED: begin
        if (arm_write) begin
          next_sync_state = SYNC_ARMED;
        end
        // later edges only mark the sticky status bit
        ignored_edge = sysref_edge;
      end
      SYNC_TRACK: begin
        // continuous mode realigns on every edge; other codes hold
        align_event = sysref_edge & mode_continuous;
        if (arm_write) begin
          next_sync_state = SYNC_ARMED;
        end
      end
      default: begin
        next_sync_state = SYNC_OFF;
      end
    endcase
    // disable forces off and drops any event of this cycle
    if (!sync_enable) begin
      next_sync_state = SYNC_OFF;
      align_event     = 1'b0;
      ignored_edge    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_state <= SYNC_OFF;
    end else begin
      sync_state <= next_sync_state;
    end
  end

  // lmfc phase counter; reset on trigger when rotation mode asks for it
  // free running between triggers; the trigger reset lands the counter
  // on zero in the align pulse cycle
  logic [LMFC_W-1:0] next_lmfc;
  logic              lmfc_wrap;
  logic              lmfc_trig_reset;

  assign lmfc_wrap       = (lmfc_phase == LMFC_W'(LMFC_PERIOD - 1));
  assign lmfc_trig_reset = align_event & rot_reset;
  assign next_lmfc       = (lmfc_trig_reset | lmfc_wrap) ? '0 : LMFC_W'(lmfc_phase + 1'b1);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lmfc_phase <= '0;
    end else begin
      lmfc_phase <= next_lmfc;
    end
  end

  // pulse and level come off the same event, so the aligned level
  // rises in the cycle of the align pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_align_pulse <= 1'b0;
      sync_aligned     <= 1'b0;
    end else begin
      sync_align_pulse <= align_event;
      sync_aligned     <= is_locked(next_sync_state);
    end
  end

  // status: sticky ignored edge, saturating accepted edge count
  // an ignored edge in the cycle of a clearing arm write wins;
  // the count saturates so software can tell many edges from a wrap
  logic       ign_flag;
  logic [3:0] align_count;
  logic       stat_locked;
  logic       stat_armed;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ign_flag    <= 1'b0;
      align_count <= 4'h0;
    end else begin
      ign_flag    <= ignored_edge | (ign_flag & ~arm_write);
      if (align_event && align_count != 4'hf) begin
        align_count <= align_count + 4'h1;
      end
    end
  end

  assign stat_locked = is_locked(sync_state);
  assign stat_armed  = (sync_state == SYNC_ARMED);
  assign status_byte = {align_count,
                        ign_flag,
                        stat_locked,
                        stat_armed,
                        sync_enable};
endmodule // slx_lane_sync

// ==== hw/slx_pkg.sv ====
// shared constants and types of the lane crossbar and sync setup block
package slx_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SYNC_MODE  = 10'h03a;
  localparam logic [9:0] IDX_SYNC_CTRL  = 10'h03b;
  localparam logic [9:0] IDX_SYNC_STAT  = 10'h03c;
  localparam logic [9:0] IDX_LDLY_A     = 10'h304;
  localparam logic [9:0] IDX_LDLY_B     = 10'h305;
  localparam logic [9:0] IDX_LAT_A      = 10'h306;
  localparam logic [9:0] IDX_LAT_B      = 10'h307;
  localparam logic [9:0] IDX_XBAR_01    = 10'h308;
  localparam logic [9:0] IDX_XBAR_23    = 10'h309;
  localparam logic [9:0] IDX_XBAR_45    = 10'h30a;
  localparam logic [9:0] IDX_XBAR_67    = 10'h30b;
  // storage slots of the writable registers
  localparam int          NUM_SLOTS      = 10;
  localparam logic [3:0]  SLOT_SYNC_MODE = 4'h0;
  localparam logic [3:0]  SLOT_SYNC_CTRL = 4'h1;
  localparam logic [3:0]  SLOT_LDLY_A    = 4'h2;
  localparam logic [3:0]  SLOT_LDLY_B    = 4'h3;
  localparam logic [3:0]  SLOT_LAT_A     = 4'h4;
  localparam logic [3:0]  SLOT_LAT_B     = 4'h5;
  localparam logic [3:0]  SLOT_XBAR_0    = 4'h6;
  // crossbar field positions
  localparam int          XBAR_EVEN_LSB  = 0;
  localparam int          XBAR_ODD_LSB   = 3;
  localparam int          SEL_W          = 3;
  // sync control fields
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_ROT_LSB   = 4;
  localparam logic [3:0]  ROT_RESET_ON_TRIG = 4'hf;
  // sync mode field
  localparam int          MODE_LSB       = 0;
  localparam logic [1:0]  MODE_CONTINUOUS = 2'h1;
  localparam logic [1:0]  MODE_ONE_SHOT  = 2'h2;
  // status fields
  localparam int          STAT_EN_BIT    = 0;
  localparam int          STAT_ARMED_BIT = 1;
  localparam int          STAT_ALIGN_BIT = 2;
  localparam int          STAT_IGN_BIT   = 3;
  localparam int          STAT_CNT_LSB   = 4;
  // reset values
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [7:0]  RST_XBAR_01    = 8'h08;
  localparam logic [7:0]  RST_XBAR_23    = 8'h1a;
  localparam logic [7:0]  RST_XBAR_45    = 8'h2c;
  localparam logic [7:0]  RST_XBAR_67    = 8'h3e;
  // sync timing
  localparam int          LMFC_PERIOD_DEF = 32;

  typedef enum logic [1:0] {
    SYNC_OFF,
    SYNC_ARMED,
    SYNC_ALIGNED,
    SYNC_TRACK
  } slx_sync_e;
endpackage

// ==== hw/slx_xbar_if.sv ====
// carrier of the crossbar source selects between config and datapath
`timescale 1ns/1ps
interface slx_xbar_if #(
  parameter int NUM_LANES = 8
);
  logic [NUM_LANES-1:0][2:0] lane_src_sel;
  modport cfg  (output lane_src_sel);
  modport xbar (input  lane_src_sel);
endinterface

// ==== tb/slx_lane_sync_asserts.sv ====
// checker of the lane crossbar and sync setup block
`timescale 1ns/1ps
module slx_lane_sync_asserts
  import slx_pkg::*;
#(
  parameter int NUM_LANES = 8,
  parameter int LANE_W    = 32,
  parameter int LMFC_W      = 5,
  parameter int LMFC_PERIOD = 32
) (
  // clock and reset
  input wire logic                             sys_clk,
  input wire logic                             reset_n,
  // register bus
  input wire logic [11:0]                      avs_address,
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic [31:0]                      avs_writedata,
  input wire logic [3:0]                       avs_byteenable,
  input wire logic                             avs_waitrequest,
  // lanes and sync
  input wire logic [NUM_LANES-1:0][LANE_W-1:0] serial_lane_input_pin,
  input wire logic [NUM_LANES-1:0][LANE_W-1:0] logical_lane_data,
  input wire logic                             sysref,
  input wire logic                             sync_align_pulse,
  input wire logic                             sync_aligned,
  input wire logic [LMFC_W-1:0]                lmfc_phase
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [NUM_LANES-1:0][2:0]        sel;
  logic [NUM_LANES-1:0][LANE_W-1:0] picked;
  logic [7:0]                       ctrl;
  logic [7:0]                       mode;
  logic [1:0]                       npulse;
  logic                             up;
  logic [LMFC_W-1:0]                step;
  wire  [9:0]                       idx = avs_address[11:2];
  wire                              commit = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire                              arm = commit && (idx == IDX_SYNC_MODE || idx == IDX_SYNC_CTRL);
  wire                              rot_hit = sync_align_pulse && ctrl[7:4] == ROT_RESET_ON_TRIG;
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_pick
    assign picked[l] = serial_lane_input_pin[sel[l]];
  end
  // shadow of the selects and sync settings, pulses since last arm
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel <= 24'hfac688;
      ctrl <= 8'h00;
      mode <= 8'h00;
      npulse <= 2'h0;
      up <= 1'b0;
      step <= '0;
    end else begin
      up <= 1'b1;
      step <= (lmfc_phase == LMFC_W'(LMFC_PERIOD - 1)) ? '0 : LMFC_W'(lmfc_phase + 1'b1);
      if (commit && idx[9:2] == 8'hc2) sel[idx[1:0]*2 +: 2] <= avs_writedata[5:0];
      if (commit && idx == IDX_SYNC_CTRL) ctrl <= avs_writedata[7:0];
      if (commit && idx == IDX_SYNC_MODE) mode <= avs_writedata[7:0];
      if (arm) npulse <= 2'h0;
      else if (sync_align_pulse && npulse != 2'h3) npulse <= npulse + 2'h1;
    end
  end
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_answer)
    else $error("bus answer not after one wait cycle");
  AST_LANE01: assert property (up |-> logical_lane_data[1:0] == $past(picked[1:0]))
    else $error("lanes 0 and 1 wrong source");
  AST_LANE27: assert property (up |-> logical_lane_data[NUM_LANES-1:2] == $past(picked[NUM_LANES-1:2]))
    else $error("lanes 2 to 7 wrong source");
  AST_ALIGN_EDGE: assert property (sync_align_pulse |-> $past(sysref) && !$past(sysref, 2) && sync_aligned)
    else $error("align pulse without sysref edge");
  AST_ROT_RESET: assert property (sync_align_pulse && ctrl[7:4] == ROT_RESET_ON_TRIG |-> lmfc_phase == '0)
    else $error("phase not reset on trigger");
  AST_ONE_SHOT: assert property (mode[1:0] == MODE_ONE_SHOT |-> npulse <= 2'h1)
    else $error("second alignment in one-shot mode");
  AST_LMFC_STEP: assert property (up && !rot_hit |-> lmfc_phase == step)
    else $error("phase counter left its free-running step");
endmodule // slx_lane_sync_asserts
bind slx_lane_sync slx_lane_sync_asserts #(.NUM_LANES(NUM_LANES), .LANE_W(LANE_W), .LMFC_W(LMFC_W),
  .LMFC_PERIOD(LMFC_PERIOD)) u_asserts (
  .sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .serial_lane_input_pin, .logical_lane_data, .sysref, .sync_align_pulse, .sync_aligned, .lmfc_phase);

// ==== tb/slx_tx_model.sv ====
// transmitter model: tagged lane words and sysref pulses
`timescale 1ns/1ps
module slx_tx_model #(
  parameter int NUM_LANES = 8
) (
  // clock and command
  input  wire logic                         sys_clk,
  input  wire logic                         sysref_req,
  // toward the device
  output logic      [NUM_LANES-1:0][31:0]   serial_lane_input_pin,
  output logic                              sysref
);
  logic [23:0] cnt = '0;
  logic [2:0]  hold = '0;
  // lane number in the top byte, running count below
  always_comb begin
    for (int l = 0; l < NUM_LANES; l++) serial_lane_input_pin[l] = {8'(l), cnt};
  end
  assign sysref = (hold != 3'h0);
  always @(posedge sys_clk) begin
    cnt <= cnt + 24'h1;
    if (sysref_req) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
endmodule // slx_tx_model

// ==== tb/tb_slx_lane_sync.sv ====
// self-checking bench of the lane crossbar and sync setup block
`timescale 1ns/1ps
module tb_slx_lane_sync;
  import slx_pkg::*;
  logic             sys_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic [11:0]      avs_address = '0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = '0;
  logic [3:0]       avs_byteenable = 4'hf;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [7:0][31:0] serial_lane_input_pin;
  logic [7:0][31:0] logical_lane_data;
  logic             sysref;
  logic             sysref_req = 1'b0;
  logic             sync_align_pulse;
  logic             sync_aligned;
  logic [4:0]       lmfc_phase;
  logic [7:0]       link_delay_a_cfg, link_delay_b_cfg, latency_setup_a_cfg, latency_setup_b_cfg;
  logic [31:0]      q;
  int               errors = 0;
  int               checks = 0;
  int               npulse = 0;
  logic             rot_on = 1'b1;
  always #12.5 sys_clk = ~sys_clk;
  slx_tx_model u_tx (.sys_clk, .sysref_req, .serial_lane_input_pin, .sysref);
  slx_lane_sync dut (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .serial_lane_input_pin, .logical_lane_data, .sysref, .sync_align_pulse,
    .sync_aligned, .lmfc_phase, .link_delay_a_cfg, .link_delay_b_cfg, .latency_setup_a_cfg, .latency_setup_b_cfg);
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access: held until waitrequest is sampled low, released after
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  // one sysref edge, then count the alignments it caused
  task automatic fire(input int exp);
    npulse = 0;
    sysref_req <= 1'b1;
    @(posedge sys_clk);
    sysref_req <= 1'b0;
    repeat (12) @(posedge sys_clk);
    chk(npulse, exp);
  endtask
  // reversed mapping: lane l fed by physical input 7-l
  function automatic logic [7:0] xr(input int k);
    return {2'b00, 3'(6 - 2 * k), 3'(7 - 2 * k)};
  endfunction
  always @(posedge sys_clk) begin
    if (sync_align_pulse === 1'b1) begin
      npulse++;
      if (rot_on) chk({27'h0, lmfc_phase}, 32'h0);
      chk({31'h0, sync_aligned}, 32'h1);
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int k = 0; k < 4; k++) rd(IDX_XBAR_01 + 10'(k), 8'(8 + 18 * k));
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, IDX_XBAR_01 + 10'(k), xr(k));
      rd(IDX_XBAR_01 + 10'(k), xr(k));
    end
    repeat (3) @(posedge sys_clk);
    for (int l = 0; l < 8; l++) chk({24'h0, logical_lane_data[l][31:24]}, 32'(7 - l));
    avs_byteenable <= 4'h0;
    bus(1'b1, IDX_XBAR_01, 8'h00);
    avs_byteenable <= 4'hf;
    rd(IDX_XBAR_01, xr(0));
    bus(1'b1, 10'h300, 8'h5a);
    rd(10'h300, 8'h00);
    bus(1'b1, IDX_LAT_A, 8'h0c);
    bus(1'b1, IDX_LAT_B, 8'h0c);
    bus(1'b1, IDX_LDLY_A, 8'h15);
    bus(1'b1, IDX_LDLY_B, 8'h2a);
    chk({link_delay_a_cfg, link_delay_b_cfg, latency_setup_a_cfg, latency_setup_b_cfg}, 32'h152a0c0c);
    bus(1'b1, IDX_SYNC_CTRL, 8'hf1);
    bus(1'b1, IDX_SYNC_MODE, 8'h02);
    fire(1);
    fire(0);
    rd(IDX_SYNC_STAT, 8'h1d);
    bus(1'b1, IDX_SYNC_MODE, 8'h02);
    fire(1);
    bus(1'b1, IDX_SYNC_MODE, 8'h01);
    fire(1);
    fire(1);
    bus(1'b1, IDX_SYNC_CTRL, 8'h00);
    fire(0);
    rot_on = 1'b0;
    bus(1'b1, IDX_SYNC_CTRL, 8'h01);
    bus(1'b1, IDX_SYNC_MODE, 8'h00);
    fire(1);
    fire(0);
    rd(IDX_SYNC_STAT, 8'h55);
    report_and_stop;
  end
endmodule // tb_slx_lane_sync
